// [llsfi_pkg.sv]
// Package for the link-layer status and fault-injection register bank
package llsfi_pkg;
    // Register byte addresses
    localparam logic [11:0] ADDR_EVENT_STATUS = 12'h394;
    localparam logic [11:0] ADDR_ACK_TO_NAK = 12'h398;
    localparam logic [11:0] ADDR_FAULT_CTRL = 12'h39c;
    localparam logic [11:0] ADDR_LINK_PAYLOAD = 12'h3a0;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    // Writable bits of the event status register (W1C)
    localparam logic [31:0] STATUS_MASK = 32'hffeb_007f;
    // Writable bits of the two injector registers
    localparam logic [31:0] ACK_NAK_MASK = 32'h00ff_0fff;
    localparam logic [31:0] FAULT_CTRL_MASK = 32'h8fff_110f;
    // Field positions
    localparam int ACK_EN_BIT = 31;
    localparam int ACK_CNT_LSB = 16;
    localparam int ACK_SEQ_LSB = 0;
    localparam int DLLP_CRC_ON_BIT = 31;
    localparam int DLLP_IVL_LSB = 16;
    localparam int SEND_TRIG_BIT = 12;
    localparam int SEQ_TRIG_BIT = 8;
    localparam int TLP_CRC_ON_BIT = 3;
    localparam int TLP_SPC_LSB = 0;
    // Clock periods per interval unit of DLLP CRC corruption
    localparam int DLLP_IVL_UNIT = 256;

    // Link-layer event strobes, one bit per status flag position
    typedef struct packed {
        logic [31:0] bits;
    } llsfi_event_t;

    // Transmit-side opportunities offered by the link layer
    typedef struct packed {
        logic ack_go;
        logic [11:0] ack_seq;
        logic dllp_go;
        logic tlp_go;
        logic link_slot;
    } llsfi_tx_t;

    // Injection commands back to the link layer
    typedef struct packed {
        logic ack_as_nak;
        logic dllp_crc_bad;
        logic tlp_lcrc_bad;
        logic tlp_seq_bad;
        logic link_send;
        logic [31:0] link_data;
    } llsfi_inj_t;

    typedef enum logic [1:0] {
        LLSFI_IDLE = 2'b00,
        LLSFI_ACK = 2'b01
    } llsfi_bus_t;
endpackage

// [llsfi_top.sv]
// Link-layer status flags and fault injectors with a Wishbone slave
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Status flags sticky, write one clears
// - Bad TLP cause flags set, informational
// - Duplicate TLP sets its flag
// - Received NAK sets its flag
// - Deskew overflow flags and forces Recovery
// - Transmit underflow sets its flag
// - Replay start sets its flag
// - Late transmit parity error sets flag
// - Replay ECC errors set their flags
// - Error flags sticky and forwarded to AER
// - Enable write loads and arms ACK injector
// - Armed injector turns matching ACKs into NAKs
// - DLLP CRC corruption single or periodic
// - Trigger edge sends one payload DLLP
// - Trigger edge spoils next TLP sequence
// - LCRC corruption every TLP or spaced
module llsfi_top #(
    parameter int SEQ_W = 12, // Sequence number width
    parameter int CNT_W = 8 // ACK-to-NAK count width
) (
    input wire logic i_clock, // Core clock, 100 MHz
    input wire logic i_nrst, // Asynchronous reset, active low
    input wire logic i_ce, // Clock enable, freezes all state
    input wire logic i_wb_cyc, // Wishbone cycle
    input wire logic i_wb_stb, // Wishbone strobe
    input wire logic i_wb_we, // Wishbone write enable
    input wire logic [11:0] i_wb_adr, // Wishbone byte address
    input wire logic [3:0] i_wb_sel, // Wishbone byte selects
    input wire logic [31:0] i_wb_dat, // Wishbone write data
    output logic [31:0] o_wb_dat, // Wishbone read data
    output logic o_wb_ack, // Wishbone acknowledge
    input wire llsfi_pkg::llsfi_event_t i_event, // Event strobes
    input wire llsfi_pkg::llsfi_tx_t i_tx, // Transmit opportunities
    output llsfi_pkg::llsfi_inj_t o_inj, // Injection commands
    output logic o_force_recovery, // Drive link to Recovery
    output logic [6:0] o_aer_errors // Error flags to AER capability
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic req;
    logic wr_stb;
    logic [31:0] byte_mask;
    logic [31:0] status_r;
    logic [31:0] ack_nak_r;
    logic [31:0] fault_ctrl_r;
    logic [31:0] payload_r;
    logic [31:0] fault_prev_r;
    llsfi_pkg::llsfi_bus_t bus_r;

    // Expand byte selects into a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Write data merged into an old value under a bit mask
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [31:0] msk);
        merge = (old & ~msk) | (dat & msk);
    endfunction

    // Request is new only while no ack is outstanding
    assign req = i_wb_cyc && i_wb_stb && (bus_r == llsfi_pkg::LLSFI_IDLE);
    // Writes land at the edge where the master samples ack high, not at the
    // request edge, so a write and its termination fall on one edge
    assign wr_stb = i_wb_cyc && i_wb_stb && i_wb_we && (bus_r == llsfi_pkg::LLSFI_ACK);
    assign byte_mask = lane_mask(i_wb_sel);

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            bus_r <= llsfi_pkg::LLSFI_IDLE;
            o_wb_ack <= 1'b0;
        end else if (i_ce) begin
            bus_r <= req ? llsfi_pkg::LLSFI_ACK : llsfi_pkg::LLSFI_IDLE;
            o_wb_ack <= req;
        end
    end

    // Read mux; unmapped addresses read zero and still ack
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wb_dat <= llsfi_pkg::RESET_VALUE;
        end else if (i_ce && req && !i_wb_we) begin
            unique case (i_wb_adr)
                llsfi_pkg::ADDR_EVENT_STATUS: o_wb_dat <= status_r;
                llsfi_pkg::ADDR_ACK_TO_NAK: o_wb_dat <= ack_nak_r;
                llsfi_pkg::ADDR_FAULT_CTRL: o_wb_dat <= fault_ctrl_r;
                llsfi_pkg::ADDR_LINK_PAYLOAD: o_wb_dat <= payload_r;
                default: o_wb_dat <= llsfi_pkg::RESET_VALUE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event status flags
    logic status_wr;
    logic [31:0] status_clr;
    assign status_wr = wr_stb && (i_wb_adr == llsfi_pkg::ADDR_EVENT_STATUS);
    assign status_clr = status_wr ? (i_wb_dat & byte_mask) : 32'h0000_0000;

    // Set wins over a same-cycle clear so no event is lost
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            status_r <= llsfi_pkg::RESET_VALUE;
        end else if (i_ce) begin
            status_r <= ((status_r & ~status_clr) | i_event.bits)
                        & llsfi_pkg::STATUS_MASK;
        end
    end

    // Overflow drives Recovery; error flags forwarded to AER
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_force_recovery <= 1'b0;
            o_aer_errors <= 7'h00;
        end else if (i_ce) begin
            o_force_recovery <= i_event.bits[23];
            o_aer_errors <= status_r[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parameter registers; software sets fields before enables
    logic ack_wr;
    logic fault_wr;
    assign ack_wr = wr_stb && (i_wb_adr == llsfi_pkg::ADDR_ACK_TO_NAK);
    assign fault_wr = wr_stb && (i_wb_adr == llsfi_pkg::ADDR_FAULT_CTRL);

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_nak_r <= llsfi_pkg::RESET_VALUE;
            fault_ctrl_r <= llsfi_pkg::RESET_VALUE;
            payload_r <= llsfi_pkg::RESET_VALUE;
        end else if (i_ce) begin
            if (ack_wr) begin
                ack_nak_r <= merge(ack_nak_r, i_wb_dat, byte_mask & llsfi_pkg::ACK_NAK_MASK);
            end
            if (fault_wr) begin
                fault_ctrl_r <= merge(fault_ctrl_r, i_wb_dat,
                                      byte_mask & llsfi_pkg::FAULT_CTRL_MASK);
            end
            if (wr_stb && (i_wb_adr == llsfi_pkg::ADDR_LINK_PAYLOAD)) begin
                payload_r <= merge(payload_r, i_wb_dat, byte_mask);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ACK-to-NAK injector
    logic [SEQ_W-1:0] inj_seq_r;
    logic [CNT_W-1:0] inj_left_r;
    logic ack_arm;
    logic ack_hit;
    logic ack_as_nak_r;
    // Enable bit is a strobe: it is never stored, so it reads zero
    assign ack_arm = ack_wr && i_wb_sel[3] && i_wb_dat[llsfi_pkg::ACK_EN_BIT];
    assign ack_hit = i_tx.ack_go && (inj_left_r != '0) &&
                     (i_tx.ack_seq[SEQ_W-1:0] == inj_seq_r);

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            inj_seq_r <= '0;
            inj_left_r <= '0;
            ack_as_nak_r <= 1'b0;
        end else if (i_ce) begin
            ack_as_nak_r <= ack_hit;
            if (ack_arm) begin
                inj_seq_r <= ack_nak_r[llsfi_pkg::ACK_SEQ_LSB +: SEQ_W];
                inj_left_r <= ack_nak_r[llsfi_pkg::ACK_CNT_LSB +: CNT_W];
            end else if (ack_hit) begin
                inj_left_r <= inj_left_r - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on trigger and enable bits
    logic [31:0] fault_rise;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            fault_prev_r <= llsfi_pkg::RESET_VALUE;
        end else if (i_ce) begin
            fault_prev_r <= fault_ctrl_r;
        end
    end
    assign fault_rise = fault_ctrl_r & ~fault_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // DLLP CRC corruption
    logic dllp_on;
    logic [11:0] dllp_ivl;
    logic [19:0] dllp_tmr_r;
    logic dllp_due_r;
    logic dllp_hit;
    logic dllp_bad_r;
    // Timer is 20 bits: the largest interval times 256 still fits
    assign dllp_on = fault_ctrl_r[llsfi_pkg::DLLP_CRC_ON_BIT];
    assign dllp_ivl = fault_ctrl_r[llsfi_pkg::DLLP_IVL_LSB +: 12];
    assign dllp_hit = dllp_on && dllp_due_r && i_tx.dllp_go;

    // One pending corruption per enable edge, then per interval period
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            dllp_tmr_r <= 20'h00000;
            dllp_due_r <= 1'b0;
            dllp_bad_r <= 1'b0;
        end else if (i_ce) begin
            dllp_bad_r <= dllp_hit;
            if (!dllp_on) begin
                dllp_tmr_r <= 20'h00000;
                dllp_due_r <= 1'b0;
            end else if (fault_rise[llsfi_pkg::DLLP_CRC_ON_BIT]) begin
                dllp_due_r <= 1'b1;
                dllp_tmr_r <= 20'h00000;
            end else begin
                if (dllp_ivl != 12'h000 &&
                    dllp_tmr_r == 20'(dllp_ivl * llsfi_pkg::DLLP_IVL_UNIT - 1)) begin
                    dllp_tmr_r <= 20'h00000;
                    dllp_due_r <= 1'b1;
                end else begin
                    if (dllp_ivl != 12'h000) begin
                        dllp_tmr_r <= dllp_tmr_r + 20'h00001;
                    end
                    if (dllp_hit) begin
                        dllp_due_r <= 1'b0;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Payload DLLP send and sequence spoil, one per trigger edge
    logic send_pend_r;
    logic seq_pend_r;
    logic link_send_r;
    logic [31:0] link_data_r;
    logic seq_bad_r;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            send_pend_r <= 1'b0;
            seq_pend_r <= 1'b0;
            link_send_r <= 1'b0;
            link_data_r <= llsfi_pkg::RESET_VALUE;
            seq_bad_r <= 1'b0;
        end else if (i_ce) begin
            link_send_r <= send_pend_r && i_tx.link_slot;
            link_data_r <= payload_r;
            seq_bad_r <= seq_pend_r && i_tx.tlp_go;
            if (fault_rise[llsfi_pkg::SEND_TRIG_BIT]) begin
                send_pend_r <= 1'b1;
            end else if (i_tx.link_slot) begin
                send_pend_r <= 1'b0;
            end
            if (fault_rise[llsfi_pkg::SEQ_TRIG_BIT]) begin
                seq_pend_r <= 1'b1;
            end else if (i_tx.tlp_go) begin
                seq_pend_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // TLP LCRC corruption with spacing; skip count cleared while off
    logic tlp_on;
    logic [2:0] tlp_spc;
    logic [2:0] tlp_skip_r;
    logic lcrc_bad_r;
    assign tlp_on = fault_ctrl_r[llsfi_pkg::TLP_CRC_ON_BIT];
    assign tlp_spc = fault_ctrl_r[llsfi_pkg::TLP_SPC_LSB +: 3];

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tlp_skip_r <= 3'h0;
            lcrc_bad_r <= 1'b0;
        end else if (i_ce) begin
            lcrc_bad_r <= tlp_on && i_tx.tlp_go && (tlp_skip_r == 3'h0);
            if (!tlp_on) begin
                tlp_skip_r <= 3'h0;
            end else if (i_tx.tlp_go) begin
                tlp_skip_r <= (tlp_skip_r == 3'h0) ? tlp_spc : tlp_skip_r - 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Injection command bundle; every field is a flop kept in its injector's process
    // above, and the bundle is formed once here so that no two processes
    // write parts of one output variable
    assign o_inj = {
        ack_as_nak_r,
        dllp_bad_r,
        lcrc_bad_r,
        seq_bad_r,
        link_send_r,
        link_data_r
    };

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sticky_hold_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (i_ce && status_r[0] && !status_clr[0]) |=> status_r[0])
        else $error("status flag lost without clear");
    set_wins_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (i_ce && i_event.bits[24]) |=> status_r[24])
        else $error("event not latched");
    recov_force_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (i_ce && i_event.bits[23]) |=> o_force_recovery)
        else $error("recovery not forced");
    aer_fwd_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce |=> (o_aer_errors == $past(status_r[6:0])))
        else $error("aer flags not forwarded");
    ack_load_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (i_ce && ack_arm) |=> (inj_left_r == $past(ack_nak_r[23:16])))
        else $error("injector count not loaded");
    nak_count_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (i_ce && ack_hit && !ack_arm) |=> (inj_left_r == $past(inj_left_r) - 1'b1))
        else $error("nak count not decremented");
    send_once_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (i_ce && o_inj.link_send && !$past(fault_rise[12])) |-> !send_pend_r)
        else $error("payload dllp sent twice");
    lcrc_all_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (i_ce && tlp_on && tlp_spc == 3'h0 && tlp_skip_r == 3'h0 && i_tx.tlp_go)
        |=> o_inj.tlp_lcrc_bad)
        else $error("lcrc not corrupted");
    edge_pend_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (i_ce && fault_rise[8]) |=> seq_pend_r)
        else $error("trigger edge missed");
endmodule
`default_nettype wire

// [llsfi_top_tb.sv]
// Self-checking bench for the link-layer status and fault-injection bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module llsfi_top_tb;
    localparam logic [11:0] A_ST = llsfi_pkg::ADDR_EVENT_STATUS;
    localparam logic [11:0] A_AN = llsfi_pkg::ADDR_ACK_TO_NAK;
    localparam logic [11:0] A_FC = llsfi_pkg::ADDR_FAULT_CTRL;
    localparam logic [11:0] A_PL = llsfi_pkg::ADDR_LINK_PAYLOAD;
    logic i_clock = 1'h0;
    logic i_nrst = 1'h0;
    logic cyc = 1'h0;
    logic ce = 1'h1;
    logic we = 1'h0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    llsfi_pkg::llsfi_event_t ev = '0;
    llsfi_pkg::llsfi_tx_t tx = '0;
    llsfi_pkg::llsfi_inj_t inj;
    logic force_rec;
    logic [6:0] aer;
    logic [31:0] got;
    int num_errors = 0;
    int n_compared = 0;
    int hits;

    // Bus strobe and cycle share one driver, so they always rise together
    llsfi_top llsfi_top_i (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_ce(ce),
        .i_wb_cyc(cyc),
        .i_wb_stb(cyc),
        .i_wb_we(we),
        .i_wb_adr(adr),
        .i_wb_sel(4'hf),
        .i_wb_dat(wdat),
        .o_wb_dat(rdat),
        .o_wb_ack(ack),
        .i_event(ev),
        .i_tx(tx),
        .o_inj(inj),
        .o_force_recovery(force_rec),
        .o_aer_errors(aer)
    );

    // 100 MHz core clock
    initial begin
        forever #5 i_clock = ~i_clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, printed once from here only
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clock);
        cyc <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge i_clock);
            if (ack === 1'h1) break;
        end
        got = rdat;
        cyc <= 1'h0;
        we <= 1'h0;
        if (n == 20) begin
            num_errors++;
            $display("[FAIL] t=%0t ack timeout got=%h exp=%h", $time, ack, 1'h1);
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        wb_xfer(1'h1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        wb_xfer(1'h0, a, 32'h0000_0000);
        `CHK(got, e)
    endtask

    // One-cycle transmit opportunity; outputs are looked at one cycle later
    task automatic go(input logic [15:0] t);
        @(posedge i_clock);
        tx <= t;
        @(posedge i_clock);
        tx <= '0;
        #1;
    endtask

    // One-cycle event strobe
    task automatic pulse_ev(input logic [31:0] b);
        @(posedge i_clock);
        ev <= b;
        @(posedge i_clock);
        ev <= '0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge i_clock);
        i_nrst <= 1'h1;
        // Reset values, and the hole just past the bank
        for (int i = 0; i < 5; i++) rd(A_ST + 12'(4 * i), 32'h0000_0000);
        wr(A_AN, 32'h7fff_ffff);
        rd(A_AN, llsfi_pkg::ACK_NAK_MASK);
        // Trigger and enable bits are kept low here so nothing gets armed
        wr(A_FC, 32'h7fff_eef7);
        rd(A_FC, 32'h0fff_0007);
        wr(A_FC, 32'h0000_0000);
        wr(A_PL, 32'ha5c3_1e69);
        rd(A_PL, 32'ha5c3_1e69);
        wr(12'h3a4, 32'hffff_ffff);
        rd(12'h3a4, 32'h0000_0000);
        // Each status position alone: sticky, zero-write keeps, one-write clears
        for (int b = 0; b < 32; b++) begin
            pulse_ev(32'h1 << b);
            `CHK(force_rec, 1'(b == 23))
            rd(A_ST, (32'h1 << b) & llsfi_pkg::STATUS_MASK);
            `CHK(aer, 7'((32'h1 << b) & 32'h7f))
            wr(A_ST, 32'h0000_0000);
            rd(A_ST, (32'h1 << b) & llsfi_pkg::STATUS_MASK);
            wr(A_ST, 32'hffff_ffff);
            rd(A_ST, 32'h0000_0000);
        end
        // Clock enable low: an event strobe must reach neither flag nor Recovery
        ce <= 1'h0;
        pulse_ev(32'h0080_0000);
        `CHK(force_rec, 1'h0)
        @(posedge i_clock);
        ce <= 1'h1;
        rd(A_ST, 32'h0000_0000);
        // ACK-to-NAK: fields first, then the enable write; count of two
        wr(A_AN, 32'h0002_0123);
        wr(A_AN, 32'h8002_0123);
        rd(A_AN, 32'h0002_0123);
        go({1'h1, 12'h124, 3'h0});
        `CHK(inj.ack_as_nak, 1'h0)
        for (int k = 0; k < 3; k++) begin
            go({1'h1, 12'h123, 3'h0});
            `CHK(inj.ack_as_nak, 1'(k < 2))
        end
        // Sequence spoiling: one TLP per rising edge, none for a held bit
        wr(A_FC, 32'h0000_0100);
        for (int k = 0; k < 2; k++) begin
            go(16'h0002);
            `CHK(inj.tlp_seq_bad, 1'(k == 0))
        end
        wr(A_FC, 32'h0000_0100);
        go(16'h0002);
        `CHK(inj.tlp_seq_bad, 1'h0)
        wr(A_FC, 32'h0000_0000);
        // Injected link packet carries the payload register
        wr(A_PL, 32'h1234_5678);
        wr(A_FC, 32'h0000_1000);
        go(16'h0001);
        `CHK(inj.link_send, 1'h1)
        `CHK(inj.link_data, 32'h1234_5678)
        go(16'h0001);
        `CHK(inj.link_send, 1'h0)
        wr(A_FC, 32'h0000_0000);
        // LCRC spacing two: one bad, two intact, repeat
        wr(A_FC, 32'h0000_0002);
        wr(A_FC, 32'h0000_000a);
        for (int k = 0; k < 6; k++) begin
            go(16'h0002);
            `CHK(inj.tlp_lcrc_bad, 1'(k % 3 == 0))
        end
        wr(A_FC, 32'h0000_0002);
        wr(A_FC, 32'h0000_0000);
        wr(A_FC, 32'h0000_0008);
        for (int k = 0; k < 2; k++) begin
            go(16'h0002);
            `CHK(inj.tlp_lcrc_bad, 1'h1)
        end
        wr(A_FC, 32'h0000_0000);
        // Link packet CRC, interval zero gives a single corruption
        wr(A_FC, 32'h8000_0000);
        for (int k = 0; k < 2; k++) begin
            go(16'h0004);
            `CHK(inj.dllp_crc_bad, 1'(k == 0))
        end
        wr(A_FC, 32'h0000_0000);
        // Interval one: a corruption every 256 cycles while offered every cycle;
        // the output is looked at just after the edge that launches it
        wr(A_FC, 32'h0001_0000);
        wr(A_FC, 32'h8001_0000);
        hits = 0;
        for (int k = 0; k < 600; k++) begin
            @(posedge i_clock);
            tx <= 16'h0004;
            #1;
            if (inj.dllp_crc_bad === 1'h1) hits++;
        end
        @(posedge i_clock);
        tx <= '0;
        `CHK(hits, 3)
        wr(A_FC, 32'h0000_0000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
